/* rtl/ocd_decoder.sv */
`timescale 1ns/1ps
`include "ocd_consts.svh"
module ocd_decoder
  import ocd_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // host port
  input wire logic i_dc,
  input wire logic i_rw,
  input wire logic i_en,
  input wire logic [7:0] i_data,
  // settings
  output logic [7:0] o_col_addr,
  output logic [5:0] o_start_line,
  output logic [7:0] o_contrast,
  output logic o_scroll_on,
  output logic [2:0] o_scroll_cols,
  output logic [2:0] o_scroll_first,
  output logic [2:0] o_scroll_last,
  output logic [8:0] o_scroll_frames,
  output logic [5:0] o_pw_bank0,
  output logic [5:0] o_pw_a,
  output logic [5:0] o_pw_b,
  output logic [5:0] o_pw_c,
  output logic [6:0] o_pw_d,
  // bank 0 drive pulse
  input wire logic i_drive_bank0,
  output logic o_pulse_bank0
);
  // ------------------------------
  // state
  // ------------------------------
  ocd_state_t st_ff, nxt_st;
  logic [1:0] idx_ff, nxt_idx;
  logic [3:0] col_lo_ff, nxt_col_lo, col_hi_ff, nxt_col_hi;
  logic [5:0] line_ff, nxt_line;
  logic [7:0] con_ff, nxt_con;
  logic scr_ff, nxt_scr;
  logic [2:0] cols_ff, nxt_cols, first_ff, nxt_first, last_ff, nxt_last;
  logic [1:0] intv_ff, nxt_intv;
  logic [5:0] pw_ff [4];
  logic [5:0] nxt_pw [4];
  logic [8:0] frames_ff, nxt_frames;
  logic pulse_ff;
  logic wr;
  ocd_pulse_if pif();

  assign wr = !i_dc && !i_rw && i_en;

  // ------------------------------
  // decoder
  // ------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_idx = idx_ff;
    nxt_col_lo = col_lo_ff;
    nxt_col_hi = col_hi_ff;
    nxt_line = line_ff;
    nxt_con = con_ff;
    nxt_scr = scr_ff;
    nxt_cols = cols_ff;
    nxt_first = first_ff;
    nxt_last = last_ff;
    nxt_intv = intv_ff;
    nxt_pw = pw_ff;
    if (wr) begin
      case (st_ff)
        OCD_IDLE: begin
          if (i_data[7:4] == `OCD_OP_COL_LO) begin
            nxt_col_lo = i_data[3:0];
          end else if (i_data[7:4] == `OCD_OP_COL_HI) begin
            nxt_col_hi = i_data[3:0];
          end else if (i_data[7:6] == `OCD_OP_START_LINE) begin
            nxt_line = i_data[5:0];
          end else if (i_data == `OCD_OP_SCRL_SETUP) begin
            nxt_st = OCD_SCRL;
            nxt_idx = 2'h0;
          end else if (i_data == `OCD_OP_SCRL_ON) begin
            nxt_scr = 1'b1;
          end else if (i_data == `OCD_OP_SCRL_OFF) begin
            nxt_scr = 1'b0;
          end else if (i_data == `OCD_OP_CONTRAST) begin
            nxt_st = OCD_CONTRAST;
          end else if (i_data == `OCD_OP_LUT) begin
            nxt_st = OCD_LUT;
            nxt_idx = 2'h0;
          end
        end
        OCD_SCRL: begin
          nxt_idx = idx_ff + 2'h1;
          case (idx_ff)
            2'h0: nxt_cols = i_data[2:0];
            2'h1: nxt_first = i_data[2:0];
            2'h2: nxt_intv = i_data[1:0];
            default: begin
              nxt_last = i_data[2:0];
              nxt_st = OCD_IDLE;
            end
          endcase
        end
        OCD_CONTRAST: begin
          nxt_con = i_data;
          nxt_st = OCD_IDLE;
        end
        OCD_LUT: begin
          nxt_pw[idx_ff] = i_data[5:0];
          nxt_idx = idx_ff + 2'h1;
          if (idx_ff == 2'h3) begin
            nxt_st = OCD_IDLE;
          end
        end
        default: nxt_st = OCD_IDLE;
      endcase
    end
  end

  always_comb begin
    case (nxt_intv)
      2'h0: nxt_frames = `OCD_FRAMES_00;
      2'h1: nxt_frames = `OCD_FRAMES_01;
      2'h2: nxt_frames = `OCD_FRAMES_10;
      default: nxt_frames = `OCD_FRAMES_11;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      st_ff <= OCD_IDLE;
      idx_ff <= 2'h0;
      col_lo_ff <= `OCD_RST_NIBBLE;
      col_hi_ff <= `OCD_RST_NIBBLE;
      line_ff <= `OCD_RST_START_LINE;
      con_ff <= `OCD_RST_CONTRAST;
      scr_ff <= 1'b0;
      cols_ff <= `OCD_RST_STEP_COLS;
      first_ff <= `OCD_RST_PAGE;
      last_ff <= `OCD_RST_PAGE;
      intv_ff <= `OCD_RST_INTERVAL;
      frames_ff <= `OCD_FRAMES_00;
      for (int i = 0; i < 4; i++) begin
        pw_ff[i] <= `OCD_RST_PULSE;
      end
      pulse_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      idx_ff <= nxt_idx;
      col_lo_ff <= nxt_col_lo;
      col_hi_ff <= nxt_col_hi;
      line_ff <= nxt_line;
      con_ff <= nxt_con;
      scr_ff <= nxt_scr;
      cols_ff <= nxt_cols;
      first_ff <= nxt_first;
      last_ff <= nxt_last;
      intv_ff <= nxt_intv;
      frames_ff <= nxt_frames;
      pw_ff <= nxt_pw;
      pulse_ff <= pif.busy;
    end
  end

  // ------------------------------
  // bank 0 pulse
  // ------------------------------
  assign pif.start = i_drive_bank0;
  assign pif.width = pw_ff[0];
  ocd_pulse_gen u_pulse (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .pif(pif)
  );

  assign o_col_addr = {col_hi_ff, col_lo_ff};
  assign o_start_line = line_ff;
  assign o_contrast = con_ff;
  assign o_scroll_on = scr_ff;
  assign o_scroll_cols = cols_ff;
  assign o_scroll_first = first_ff;
  assign o_scroll_last = last_ff;
  assign o_scroll_frames = frames_ff;
  assign o_pw_bank0 = pw_ff[0];
  assign o_pw_a = pw_ff[1];
  assign o_pw_b = pw_ff[2];
  assign o_pw_c = pw_ff[3];
  assign o_pw_d = `OCD_PULSE_D_CLKS;
  assign o_pulse_bank0 = pulse_ff;

  // ------------------------------
  // checks
  // ------------------------------
  chk_lo_nibble: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr && st_ff == OCD_IDLE && i_data[7:4] == 4'h0 |=> o_col_addr[3:0] == $past(i_data[3:0]))
    else $error("lower column nibble not loaded");
  chk_hi_nibble: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr && st_ff == OCD_IDLE && i_data[7:4] == 4'h1 |=> o_col_addr[7:4] == $past(i_data[3:0]))
    else $error("upper column nibble not loaded");
  chk_reset_vals: assert property (@(posedge i_clk)
    !i_rstn |=> o_col_addr == 8'h00 && o_start_line == 6'h00 && o_contrast == 8'h80)
    else $error("reset values wrong");
  chk_start_line: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr && st_ff == OCD_IDLE && i_data[7:6] == 2'h1 |=> o_start_line == $past(i_data[5:0]))
    else $error("start line not loaded");
  chk_contrast: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr && st_ff == OCD_CONTRAST |=> o_contrast == $past(i_data))
    else $error("contrast not stored");
  chk_param_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_ff == OCD_CONTRAST && !wr |=> st_ff == OCD_CONTRAST)
    else $error("parameter wait left without a write");
  chk_scroll_on: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr && st_ff == OCD_IDLE && (i_data == 8'h2F || i_data == 8'h2E) |=> o_scroll_on == $past(i_data[0]))
    else $error("scroll activate wrong");
  chk_frames: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_ff == OCD_SCRL && idx_ff == 2'h2 && wr && i_data[1:0] == 2'h0 |=> o_scroll_frames == 9'h00C)
    else $error("frame interval wrong");
  chk_pulse_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_drive_bank0 && !pif.busy && pw_ff[0] == 6'h00 |=> pif.busy ##1 !pif.busy)
    else $error("pulse width wrong");
  chk_lut_end: assert property (@(posedge i_clk) disable iff (!i_rstn)
    st_ff == OCD_LUT && idx_ff == 2'h3 && wr |=> st_ff == OCD_IDLE && o_pw_c == $past(i_data[5:0]))
    else $error("lut colour C not stored");
  cov_scroll: cover property (@(posedge i_clk) disable iff (!i_rstn) st_ff == OCD_SCRL ##[1:20] st_ff == OCD_IDLE);
  cov_lut: cover property (@(posedge i_clk) disable iff (!i_rstn) st_ff == OCD_LUT && idx_ff == 2'h3 && wr);
  cov_pulse: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(o_pulse_bank0));
endmodule

/* rtl/ocd_consts.svh */
`ifndef OCD_CONSTS_SVH
`define OCD_CONSTS_SVH
`define OCD_OP_COL_LO 4'h0
`define OCD_OP_COL_HI 4'h1
`define OCD_OP_SCRL_SETUP 8'h26
`define OCD_OP_SCRL_ON 8'h2F
`define OCD_OP_SCRL_OFF 8'h2E
`define OCD_OP_START_LINE 2'h1
`define OCD_OP_CONTRAST 8'h81
`define OCD_OP_LUT 8'h91
`define OCD_RST_NIBBLE 4'h0
`define OCD_RST_START_LINE 6'h00
`define OCD_RST_CONTRAST 8'h80
`define OCD_RST_STEP_COLS 3'h1
`define OCD_RST_PAGE 3'h0
`define OCD_RST_INTERVAL 2'h0
`define OCD_RST_PULSE 6'h3F
`define OCD_FRAMES_00 9'h00C
`define OCD_FRAMES_01 9'h040
`define OCD_FRAMES_10 9'h080
`define OCD_FRAMES_11 9'h100
`define OCD_PULSE_D_CLKS 7'h40
`endif

/* rtl/ocd_pkg.sv */
package ocd_pkg;
  typedef enum logic [2:0] {
    OCD_IDLE,
    OCD_SCRL,
    OCD_CONTRAST,
    OCD_LUT
  } ocd_state_t;
endpackage

/* rtl/ocd_pulse_if.sv */
`timescale 1ns/1ps
interface ocd_pulse_if;
  logic start;
  logic [5:0] width;
  logic busy;
  modport ctl (output start, output width, input busy);
  modport gen (input start, input width, output busy);
endinterface

/* rtl/ocd_pulse_gen.sv */
`timescale 1ns/1ps
module ocd_pulse_gen (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // request
  ocd_pulse_if.gen pif
);
  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (cnt_ff != 7'h00) begin
      nxt_cnt = cnt_ff - 7'h01;
    end else if (pif.start) begin
      nxt_cnt = {1'b0, pif.width} + 7'h01;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_ff <= 7'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign pif.busy = (cnt_ff != 7'h00);
endmodule

/* tb/ocd_host_model.sv */
`timescale 1ns/1ps
module ocd_host_model (
  // clock
  input wire logic i_clk,
  // host port
  output logic o_dc,
  output logic o_rw,
  output logic o_en,
  output logic [7:0] o_data
);
  initial begin
    o_dc = 1'b1;
    o_rw = 1'b1;
    o_en = 1'b0;
    o_data = 8'h00;
  end

  // ----------------------------------------
  // byte write
  // ----------------------------------------
  // strobe one byte every two cycles: enable high for one cycle, then low for one
  // callers keep step 1..4 and last page at or above first
  task automatic send(input logic [7:0] b, input logic is_cmd);
    @(negedge i_clk);
    o_dc = ~is_cmd;
    o_rw = 1'b0;
    o_en = 1'b1;
    o_data = b;
    @(negedge i_clk);
    o_en = 1'b0;
    o_rw = 1'b1;
    o_data = ~b;
  endtask
endmodule

/* tb/ocd_decoder_tb.sv */
`timescale 1ns/1ps
module ocd_decoder_tb;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_drive_bank0 = 1'b0;
  logic dc, rw, en;
  logic [7:0] data, col, contrast;
  logic [5:0] line, pw0, pwa, pwb, pwc;
  logic [2:0] cols, first, last;
  logic [8:0] frames;
  logic [6:0] pwd;
  logic scroll_on, pulse;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] frame_tab [4] = '{16'h000C, 16'h0040, 16'h0080, 16'h0100};

  always #2.5 i_clk = ~i_clk;

  ocd_host_model u_ocd_host_model (.i_clk(i_clk), .o_dc(dc), .o_rw(rw), .o_en(en), .o_data(data));

  ocd_decoder u_ocd_decoder (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_dc(dc), .i_rw(rw), .i_en(en), .i_data(data),
    .o_col_addr(col), .o_start_line(line), .o_contrast(contrast), .o_scroll_on(scroll_on),
    .o_scroll_cols(cols), .o_scroll_first(first), .o_scroll_last(last), .o_scroll_frames(frames),
    .o_pw_bank0(pw0), .o_pw_a(pwa), .o_pw_b(pwb), .o_pw_c(pwc), .o_pw_d(pwd),
    .i_drive_bank0(i_drive_bank0), .o_pulse_bank0(pulse)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    u_ocd_host_model.send(b, 1'b1);
  endtask

  task automatic settle();
    repeat (2) @(negedge i_clk);
  endtask

  task automatic pulse_len(input logic [5:0] w);
    int n;
    n = 0;
    cmd(8'h91);
    cmd({2'b00, w});
    cmd(8'h0A);
    cmd(8'h15);
    cmd(8'h2A);
    settle();
    check(16'(pw0), 16'(w));
    check(16'(pwa), 16'h000A);
    check(16'(pwb), 16'h0015);
    check(16'(pwc), 16'h002A);
    @(negedge i_clk);
    i_drive_bank0 = 1'b1;
    @(negedge i_clk);
    i_drive_bank0 = 1'b0;
    repeat (80) begin
      @(negedge i_clk);
      if (pulse === 1'b1) n++;
    end
    check(16'(n), 16'(w) + 16'h0001);
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge i_clk);
    i_rstn = 1'b1;
    @(negedge i_clk);
    check(16'(col), 16'h0000);
    check(16'(line), 16'h0000);
    check(16'(contrast), 16'h0080);
    check(16'(scroll_on), 16'h0000);
    check(16'(cols), 16'h0001);
    check(16'(first), 16'h0000);
    check(16'(last), 16'h0000);
    check(16'(frames), 16'h000C);
    check(16'(pwd), 16'h0040);
    cmd(8'h0A);
    cmd(8'h15);
    settle();
    check(16'(col), 16'h005A);
    cmd(8'h7F);
    settle();
    check(16'(line), 16'h003F);
    cmd(8'h40);
    settle();
    check(16'(line), 16'h0000);
    cmd(8'h81);
    u_ocd_host_model.send(8'h12, 1'b0);
    cmd(8'h33);
    settle();
    check(16'(contrast), 16'h0033);
    cmd(8'h81);
    cmd(8'hFF);
    settle();
    check(16'(contrast), 16'h00FF);
    for (int i = 0; i < 4; i++) begin
      cmd(8'h26);
      cmd(8'(i + 1));
      cmd(8'(i));
      cmd(8'(i));
      cmd(8'(i + 3));
      settle();
      check(16'(cols), 16'(i + 1));
      check(16'(first), 16'(i));
      check(16'(last), 16'(i + 3));
      check(16'(frames), frame_tab[i]);
      check(16'(scroll_on), 16'h0000);
    end
    cmd(8'h2F);
    settle();
    check(16'(scroll_on), 16'h0001);
    cmd(8'h2E);
    settle();
    check(16'(scroll_on), 16'h0000);
    pulse_len(6'h00);
    pulse_len(6'h05);
    pulse_len(6'h3F);
    print_verdict();
  end
endmodule
